// ---- rtl/lfhs_pkg.sv ----
// package: constants, register map and types for the frame header controller
package lfhs_pkg;
	// sequence arithmetic, modulo 128
	localparam logic [6:0]  SEQ_ONE       = 7'h01;
	localparam logic [6:0]  K_RESET       = 7'h07;
	localparam logic [6:0]  K_MIN         = 7'h01;
	// register byte offsets
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_CONN      = 8'h04;
	localparam logic [7:0]  REG_TXCMD     = 8'h08;
	localparam logic [7:0]  REG_STATUS    = 8'h0C;
	localparam logic [7:0]  REG_RXHDR     = 8'h10;
	// control register fields
	localparam int unsigned CTRL_TWO_BIT  = 0;
	localparam int unsigned CTRL_ORIG_BIT = 1;
	localparam int unsigned CTRL_CLR_BIT  = 2;
	localparam int unsigned CTRL_K_LSB    = 3;
	// identifier register fields
	localparam int unsigned CONN_U_LSB    = 0;
	localparam int unsigned CONN_C_LSB    = 16;
	// status register fields (flags are write-one-to-clear)
	localparam int unsigned ST_VS_LSB     = 0;
	localparam int unsigned ST_VA_LSB     = 8;
	localparam int unsigned ST_VR_LSB     = 16;
	localparam int unsigned ST_BUSY_BIT   = 24;
	localparam int unsigned ST_WIN_BIT    = 25;
	localparam int unsigned ST_NRBAD_BIT  = 26;
	localparam int unsigned ST_DROP_BIT   = 27;
	localparam int unsigned ST_RXOK_BIT   = 28;
	// reset values of the two supported connection identifiers
	localparam logic [12:0] CONN_USER_RST = 13'h0000;
	localparam logic [12:0] CONN_CTRL_RST = 13'h003F;
	// control field formats
	localparam logic [1:0]  FMT_I         = 2'h0;
	localparam logic [1:0]  FMT_S         = 2'h1;
	localparam logic [1:0]  FMT_U         = 2'h2;
	localparam logic [1:0]  FMT_BAD       = 2'h3;

	// transmit order word, low ten bits of a write to the command register
	typedef struct packed {
		logic [4:0] modf;
		logic       dsel;
		logic       pf;
		logic       cmd;
		logic [1:0] fmt;
	} lfhs_txcmd_t;

	// last accepted received header
	typedef struct packed {
		logic [4:0] modf;
		logic [6:0] nr;
		logic [6:0] ns;
		logic       dsel;
		logic       pf;
		logic       cmd;
		logic [1:0] fmt;
	} lfhs_rxhdr_t;

	typedef enum logic {TX_IDLE, TX_SEND} lfhs_tx_st_t;

	// whole state of the controller
	typedef struct packed {
		lfhs_tx_st_t      tx_st;
		logic [3:0][7:0]  tx_buf;
		logic [2:0]       tx_len;
		logic [1:0]       tx_idx;
		logic             tx_valid;
		logic             tx_last;
		logic [7:0]       tx_octet;
		logic             tx_two;
		logic [6:0]       vs;
		logic [6:0]       va;
		logic [6:0]       vr;
		logic [6:0]       k;
		logic             two;
		logic             orig;
		logic [12:0]      conn_u;
		logic [12:0]      conn_c;
		logic             win_full;
		logic             nr_bad;
		logic             rx_drop;
		logic             rx_ok;
		logic [3:0][7:0]  rx_buf;
		logic [2:0]       rx_cnt;
		lfhs_rxhdr_t      rx_hdr;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
	} lfhs_state_t;
endpackage : lfhs_pkg

// ---- rtl/lfhs_ctrl.sv ----
// frame header builder, parser and sequence state controller with an apb slave
// How it works
// (RULE_01) address field built and accepted as one or two octets only
// (RULE_02) extension flag 1 marks the last address octet, 0 means another follows
// (RULE_03) extension flag sits in bit 1, the first bit sent, of each address octet
// (RULE_04) two-octet form adds bits 8..2 of the second octet to the identifier
// (RULE_05) command/response bit depends on role and direction; identifier unchanged
// (RULE_06) information control: N(S) over bit 1 zero, then N(R) over poll bit
// (RULE_07) supervisory control: 01 low, function bits 4..3, reserved zero, N(R) and P/F
// (RULE_08) unnumbered control: one octet, 11 low, P/F in bit 5, modifiers elsewhere
// (RULE_09) lowest bit position carries the least significant bit of each parameter
// (RULE_10) every frame carries poll/final; reported on receive, set on send
// (RULE_11) all sequence numbers are seven bits and wrap modulo 128
// (RULE_12) send variable steps per information frame, never beyond window k
// (RULE_13) acknowledge variable loaded only from N(R) between V(A) and V(S)
// (RULE_14) sent N(S) equals current send variable
// (RULE_15) receive variable steps only on good in-sequence information frame
// (RULE_16) sent N(R) equals current receive variable
// (RULE_17) N(R) acknowledges all frames up to N(R) minus one
// (RULE_18) only information frames carry N(S); fields set independently
// (RULE_19) two identifier values are told apart: user data and control
// (RULE_20) over-long address or unknown identifier: frame dropped silently
// (RULE_21) octets leave in ascending order, bit 1 of each octet first on line
// (RULE_22) both identifier values are software-configurable registers
//
// Implementation choices: the APB register port and the placing of the registers.
module lfhs_ctrl
	import lfhs_pkg::*;
(
	// clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RESET,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// transmitted header octets
	output logic      [7:0]  TX_OCTET,
	output logic             TX_VALID,
	output logic             TX_LAST,
	input  wire logic        TX_READY,
	// received frame octets
	input  wire logic [7:0]  RX_OCTET,
	input  wire logic        RX_VALID,
	input  wire logic        RX_LAST,
	input  wire logic        RX_GOOD
);
	lfhs_state_t     s;
	lfhs_state_t     n;
	lfhs_txcmd_t     tc;
	logic            wr;
	logic            busy;
	logic            refuse;
	logic [6:0]      outst;
	logic [12:0]     td;
	logic            cr;
	logic [7:0]      a0;
	logic [7:0]      a1;
	logic [7:0]      c0;
	logic [7:0]      c1;
	logic [3:0][7:0] b;
	logic [2:0]      cnt;
	logic [1:0]      alen;
	logic [7:0]      r0;
	logic [7:0]      r1;
	logic [1:0]      rf;
	logic [2:0]      need;
	logic [12:0]     rd;
	logic            dok;
	logic [6:0]      rnr;
	logic            seq_clr;
	logic            tx_go;

	assign busy   = (s.tx_st == TX_SEND);
	assign outst  = 7'(s.vs - s.va); // [RULE_11]
	assign tc     = lfhs_txcmd_t'(PWDATA[9:0]);
	assign refuse = busy || (tc.fmt == FMT_BAD) || ((tc.fmt == FMT_I) && (outst >= s.k));

	// bus write strobe, accepted clear and accepted order; the checks below use them too
	assign wr      = PSEL && PENABLE && s.pready && PWRITE;
	assign seq_clr = wr && (PADDR == REG_CTRL) && PWDATA[CTRL_CLR_BIT];
	assign tx_go   = wr && (PADDR == REG_TXCMD) && !refuse;

	// next state: apb, transmit builder, receive parser
	always_comb begin
		n       = s;
		td      = tc.dsel ? s.conn_c : s.conn_u; // [RULE_19]
		cr      = ~(tc.cmd ^ s.orig); // [RULE_05]
		a0      = s.two ? {td[12:7], cr, 1'b0} : {td[5:0], cr, 1'b1}; // [RULE_02] [RULE_03]
		a1      = {td[6:0], 1'b1}; // [RULE_04]
		c0      = 8'h00;
		c1      = {s.vr, tc.pf}; // [RULE_16] [RULE_17]
		b       = s.rx_buf;
		cnt     = s.rx_cnt;
		alen    = 2'h0;
		r0      = 8'h00;
		r1      = 8'h00;
		rf      = FMT_BAD;
		need    = 3'h7;
		rd      = 13'h0000;
		dok     = 1'b0;
		rnr     = 7'h00;
		n.pready  = 1'b0;
		n.pslverr = 1'b0;
		// apb access phase seen: answer in the next cycle with data prepared now
		if (PSEL && PENABLE && !s.pready) begin
			n.pready = 1'b1;
			unique case (PADDR)
				REG_CTRL:   n.prdata = {22'h000000, s.k, 1'b0, s.orig, s.two};
				REG_CONN:   n.prdata = {3'h0, s.conn_c, 3'h0, s.conn_u};
				REG_TXCMD: begin
					n.prdata  = {31'h00000000, busy};
					n.pslverr = PWRITE && refuse;
				end
				REG_STATUS: n.prdata = {3'h0, s.rx_ok, s.rx_drop, s.nr_bad, s.win_full,
					busy, 1'b0, s.vr, 1'b0, s.va, 1'b0, s.vs};
				REG_RXHDR:  n.prdata = {8'h00, s.rx_hdr};
				default: begin
					n.prdata  = 32'h00000000;
					n.pslverr = 1'b1;
				end
			endcase
		end
		// writes take effect on the completing edge only
		if (wr && (PADDR == REG_CTRL)) begin
			n.two  = PWDATA[CTRL_TWO_BIT];
			n.orig = PWDATA[CTRL_ORIG_BIT];
			n.k    = (PWDATA[CTRL_K_LSB +: 7] == 7'h00) ? K_MIN : PWDATA[CTRL_K_LSB +: 7]; // [RULE_12]
		end
		if (wr && (PADDR == REG_CONN)) begin
			n.conn_u = PWDATA[CONN_U_LSB +: 13]; // [RULE_22]
			n.conn_c = PWDATA[CONN_C_LSB +: 13]; // [RULE_22]
		end
		// status flags clear first so a same-cycle event below wins
		if (wr && (PADDR == REG_STATUS)) begin
			if (PWDATA[ST_WIN_BIT])   n.win_full = 1'b0;
			if (PWDATA[ST_NRBAD_BIT]) n.nr_bad   = 1'b0;
			if (PWDATA[ST_DROP_BIT])  n.rx_drop  = 1'b0;
			if (PWDATA[ST_RXOK_BIT])  n.rx_ok    = 1'b0;
		end
		// transmit order: build control octets per format
		unique case (tc.fmt)
			FMT_I:   c0 = {s.vs, 1'b0}; // [RULE_06] [RULE_14] [RULE_18]
			FMT_S:   c0 = {4'h0, tc.modf[1:0], 2'b01}; // [RULE_07] [RULE_09]
			FMT_U:   c0 = {tc.modf[4:2], tc.pf, tc.modf[1:0], 2'b11}; // [RULE_08] [RULE_10]
			FMT_BAD: c0 = 8'h00;
		endcase
		if (wr && (PADDR == REG_TXCMD)) begin
			if (!busy && (tc.fmt == FMT_I) && (outst >= s.k)) begin
				n.win_full = 1'b1; // [RULE_12]
			end else if (!refuse) begin
				n.tx_st  = TX_SEND;
				n.tx_two = s.two;
				n.tx_len = 3'(3'(s.two ? 3'h2 : 3'h1) + ((tc.fmt == FMT_U) ? 3'h1 : 3'h2)); // [RULE_01]
				n.tx_buf = s.two ? {c1, c0, a1, a0} : {8'h00, c1, c0, a0}; // [RULE_21]
				n.tx_idx   = 2'h0;
				n.tx_octet = a0;
				n.tx_valid = 1'b1;
				n.tx_last  = 1'b0;
				if (tc.fmt == FMT_I) begin
					n.vs = 7'(s.vs + SEQ_ONE); // [RULE_12] [RULE_11]
				end
			end
		end
		// octet handshake toward the line side
		if (busy && s.tx_valid && TX_READY) begin
			if (s.tx_last) begin
				n.tx_st    = TX_IDLE;
				n.tx_valid = 1'b0;
				n.tx_last  = 1'b0;
			end else begin
				n.tx_idx   = 2'(s.tx_idx + 2'h1); // [RULE_21]
				n.tx_octet = s.tx_buf[n.tx_idx];
				n.tx_last  = ({1'b0, n.tx_idx} == 3'(s.tx_len - 3'h1));
			end
		end
		// receive: keep the first four octets, count saturates to mark more
		if (RX_VALID) begin
			if (s.rx_cnt < 3'h4) b[s.rx_cnt[1:0]] = RX_OCTET;
			if (s.rx_cnt < 3'h5) cnt = 3'(s.rx_cnt + 3'h1);
			n.rx_buf = b;
			n.rx_cnt = cnt;
		end
		if (RX_VALID && RX_LAST) begin
			n.rx_cnt = 3'h0;
			// a third address octet makes the frame invalid
			alen = b[0][0] ? 2'h1 : (b[1][0] ? 2'h2 : 2'h0); // [RULE_01] [RULE_02] [RULE_20]
			r0   = b[alen];
			r1   = b[2'(alen + 2'h1)];
			rf   = !r0[0] ? FMT_I : (r0[1] ? FMT_U : FMT_S); // [RULE_06] [RULE_07] [RULE_08]
			need = 3'({1'b0, alen} + ((rf == FMT_U) ? 3'h1 : 3'h2));
			rd   = (alen == 2'h2) ? {b[0][7:2], b[1][7:1]} : {7'h00, b[0][7:2]}; // [RULE_04]
			dok  = (rd == s.conn_u) || (rd == s.conn_c); // [RULE_19]
			rnr  = r1[7:1]; // [RULE_09]
			if (RX_GOOD && (alen != 2'h0) && dok && (cnt >= need)) begin
				n.rx_ok       = 1'b1;
				n.rx_hdr.fmt  = rf;
				n.rx_hdr.cmd  = b[0][1] ^ s.orig; // [RULE_05]
				n.rx_hdr.pf   = (rf == FMT_U) ? r0[4] : r1[0]; // [RULE_10]
				n.rx_hdr.dsel = (rd == s.conn_c);
				n.rx_hdr.ns   = (rf == FMT_I) ? r0[7:1] : 7'h00; // [RULE_18]
				n.rx_hdr.nr   = (rf == FMT_U) ? 7'h00 : rnr;
				n.rx_hdr.modf = (rf == FMT_U) ? {r0[7:5], r0[3:2]} : {3'h0, r0[3:2]};
				if ((rf == FMT_I) && (r0[7:1] == s.vr)) begin
					n.vr = 7'(s.vr + SEQ_ONE); // [RULE_15]
				end
				if (rf != FMT_U) begin
					// valid when nr - va does not pass vs - va, both modulo 128
					if (7'(rnr - s.va) <= outst) begin
						n.va = rnr; // [RULE_13] [RULE_17]
					end else begin
						n.nr_bad = 1'b1;
					end
				end
			end else begin
				n.rx_drop = 1'b1; // [RULE_20]
			end
		end
		// clearing the sequence state overrides anything above
		if (wr && (PADDR == REG_CTRL) && PWDATA[CTRL_CLR_BIT]) begin
			n.vs = 7'h00;
			n.va = 7'h00;
			n.vr = 7'h00;
		end
	end

	// state register
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			s        <= '0;
			s.k      <= K_RESET;
			s.conn_u <= CONN_USER_RST;
			s.conn_c <= CONN_CTRL_RST;
		end else begin
			s <= n;
		end
	end

	// outputs straight from the state flops
	assign PRDATA   = s.prdata;
	assign PREADY   = s.pready;
	assign PSLVERR  = s.pslverr;
	assign TX_OCTET = s.tx_octet;
	assign TX_VALID = s.tx_valid;
	assign TX_LAST  = s.tx_last;

	// checks on the design's own outputs and state
	// software may lower k below the outstanding count, so only a step of vs is judged
	property p_window;
		@(posedge CLOCK) disable iff (RESET)
		((n.vs != s.vs) && !seq_clr) |-> (outst < s.k);
	endproperty
	a_window: assert property (p_window) else $error("window exceeded"); // [RULE_12]

	property p_ext_first;
		@(posedge CLOCK) disable iff (RESET)
		(TX_VALID && (s.tx_idx == 2'h0)) |-> (TX_OCTET[0] == !s.tx_two);
	endproperty
	a_ext_first: assert property (p_ext_first) else $error("bad address extension"); // [RULE_02]

	property p_addr_len;
		@(posedge CLOCK) disable iff (RESET)
		TX_VALID |-> (s.tx_len <= (s.tx_two ? 3'h4 : 3'h3));
	endproperty
	a_addr_len: assert property (p_addr_len) else $error("header too long"); // [RULE_01]

	property p_vr_step;
		@(posedge CLOCK) disable iff (RESET)
		(s.vr != $past(s.vr)) |-> ((s.vr == 7'($past(s.vr) + SEQ_ONE)) || (s.vr == 7'h00));
	endproperty
	a_vr_step: assert property (p_vr_step) else $error("receive variable jumped"); // [RULE_15]

	property p_vs_step;
		@(posedge CLOCK) disable iff (RESET)
		(s.vs != $past(s.vs)) |-> ((s.vs == 7'($past(s.vs) + SEQ_ONE)) || (s.vs == 7'h00));
	endproperty
	a_vs_step: assert property (p_vs_step) else $error("send variable jumped"); // [RULE_12]

	property p_va_range;
		@(posedge CLOCK) disable iff (RESET)
		(s.va != $past(s.va)) |->
		((7'(s.va - $past(s.va)) <= 7'($past(s.vs) - $past(s.va))) || (s.va == 7'h00));
	endproperty
	a_va_range: assert property (p_va_range) else $error("ack outside range"); // [RULE_13]

	property p_apb_answer;
		@(posedge CLOCK) disable iff (RESET)
		(PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");

	property p_tx_hold;
		@(posedge CLOCK) disable iff (RESET)
		(TX_VALID && !TX_READY) |=> (TX_VALID && $stable(TX_OCTET) && $stable(TX_LAST));
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("octet dropped"); // [RULE_21]

	property p_err_with_ready;
		@(posedge CLOCK) disable iff (RESET)
		PSLVERR |-> PREADY;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

	property p_tx_start;
		@(posedge CLOCK) disable iff (RESET)
		tx_go |=> (TX_VALID && !TX_LAST && (s.tx_idx == 2'h0));
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("header did not start"); // [RULE_21]

	property p_ext_second;
		@(posedge CLOCK) disable iff (RESET)
		(TX_VALID && s.tx_two && (s.tx_idx == 2'h1)) |-> TX_OCTET[0];
	endproperty
	a_ext_second: assert property (p_ext_second) else $error("bad second address octet"); // [RULE_02]

	property p_s_reserved;
		@(posedge CLOCK) disable iff (RESET)
		(TX_VALID && (s.tx_idx == (s.tx_two ? 2'h2 : 2'h1)) && (TX_OCTET[1:0] == 2'b01))
		|-> (TX_OCTET[7:4] == 4'h0);
	endproperty
	a_s_reserved: assert property (p_s_reserved) else $error("reserved bits set"); // [RULE_07]

	property p_u_single;
		@(posedge CLOCK) disable iff (RESET)
		(TX_VALID && (s.tx_idx == (s.tx_two ? 2'h2 : 2'h1)) && (TX_OCTET[1:0] == 2'b11))
		|-> TX_LAST;
	endproperty
	a_u_single: assert property (p_u_single) else $error("unnumbered control too long"); // [RULE_08]

	property p_tx_order;
		@(posedge CLOCK) disable iff (RESET)
		(TX_VALID && TX_READY && !TX_LAST) |=>
		(TX_VALID && (s.tx_idx == 2'($past(s.tx_idx) + 2'h1)));
	endproperty
	a_tx_order: assert property (p_tx_order) else $error("octet order broken"); // [RULE_21]

	property p_tx_end;
		@(posedge CLOCK) disable iff (RESET)
		(TX_VALID && TX_READY && TX_LAST) |=> !TX_VALID;
	endproperty
	a_tx_end: assert property (p_tx_end) else $error("header ran past its end"); // [RULE_01]

	property p_vr_source;
		@(posedge CLOCK) disable iff (RESET)
		((n.vr != s.vr) && !seq_clr) |-> (RX_VALID && RX_LAST && RX_GOOD);
	endproperty
	a_vr_source: assert property (p_vr_source) else $error("receive variable moved"); // [RULE_15]

	property p_drop_silent;
		@(posedge CLOCK) disable iff (RESET)
		(RX_VALID && RX_LAST && !RX_GOOD && !seq_clr) |=>
		($stable(s.vr) && $stable(s.va) && $stable(s.rx_hdr));
	endproperty
	a_drop_silent: assert property (p_drop_silent) else $error("bad frame changed state"); // [RULE_20]
endmodule : lfhs_ctrl

// ---- tb/lfhs_peer.sv ----
// peer entity model: sink for header octets and source of received frames
module lfhs_peer
	import lfhs_pkg::*;
(
	// clock and pacing controls
	input  wire logic       CLOCK,
	input  wire logic       SLOW,
	input  wire logic       STALL,
	// header octets from the controller
	input  wire logic [7:0] TX_OCTET,
	input  wire logic       TX_VALID,
	input  wire logic       TX_LAST,
	output logic            TX_READY,
	// frame octets to the controller
	output logic      [7:0] RX_OCTET,
	output logic            RX_VALID,
	output logic            RX_LAST,
	output logic            RX_GOOD
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [8:0] got[$];

	initial begin
		TX_READY = 1'b0;
		RX_OCTET = 8'h00;
		RX_VALID = 1'b0;
		RX_LAST  = 1'b0;
		RX_GOOD  = 1'b0;
	end

	// octets kept in line order with their end marker; slow mode takes every other cycle
	always @(posedge CLOCK) begin
		if (TX_VALID && TX_READY)
			got.push_back({TX_LAST, TX_OCTET});
		TX_READY <= !STALL && (!SLOW || !TX_READY);
	end

	// frames go out first octet first; a released octet line shows the inverse, never stale data
	task automatic send(input logic [7:0] f[$], input logic good);
		foreach (f[i]) begin
			@(posedge CLOCK);
			RX_OCTET <= f[i];
			RX_VALID <= 1'b1;
			RX_LAST  <= (i == f.size() - 1);
			RX_GOOD  <= good;
		end
		@(posedge CLOCK);
		RX_OCTET <= ~f[f.size() - 1];
		RX_VALID <= 1'b0;
		RX_LAST  <= 1'b0;
		RX_GOOD  <= 1'b0;
	endtask : send
endmodule : lfhs_peer

// ---- tb/lfhs_ctrl_tb.sv ----
// self-checking bench for the frame header controller
module lfhs_ctrl_tb;
	import lfhs_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct {
		logic [31:0] ctrl;
		logic [31:0] cmd;
		logic [31:0] oct;
		int          n;
	} lfhs_row_t;

	logic        CLOCK = 1'b0;
	logic        RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SLOW, STALL;
	logic [7:0]  PADDR, TX_OCTET, RX_OCTET;
	logic [31:0] PWDATA, PRDATA;
	logic        TX_VALID, TX_LAST, TX_READY, RX_VALID, RX_LAST, RX_GOOD;
	int          error_cnt = 0;
	int          num_checks = 0;
	// control word, order, octets first-in-low-byte, count; all four role/direction cases
	lfhs_row_t   rows[5] = '{
		'{32'h38, 32'h1EE, 32'h00007F01, 2},
		'{32'h38, 32'h19A, 32'h000073FF, 2},
		'{32'h3B, 32'h004, 32'h00000102, 4},
		'{32'h3B, 32'h059, 32'h01097F00, 4},
		'{32'h3B, 32'h00C, 32'h01020102, 4}};

	always #12.5 CLOCK = ~CLOCK;

	lfhs_ctrl uut (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .TX_OCTET(TX_OCTET), .TX_VALID(TX_VALID),
		.TX_LAST(TX_LAST), .TX_READY(TX_READY), .RX_OCTET(RX_OCTET),
		.RX_VALID(RX_VALID), .RX_LAST(RX_LAST), .RX_GOOD(RX_GOOD));

	lfhs_peer peer (.CLOCK(CLOCK), .SLOW(SLOW), .STALL(STALL), .TX_OCTET(TX_OCTET),
		.TX_VALID(TX_VALID), .TX_LAST(TX_LAST), .TX_READY(TX_READY),
		.RX_OCTET(RX_OCTET), .RX_VALID(RX_VALID), .RX_LAST(RX_LAST), .RX_GOOD(RX_GOOD));

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	endtask : chk

	// one apb transfer; an idle cycle follows so no strobe is assigned twice in a step
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] x, input logic e);
		int t;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		t = 0;
		do begin
			@(posedge CLOCK);
			t++;
		end while (PREADY !== 1'b1 && t < 20);
		if (t >= 20) begin
			chk("pready", 1, PREADY);
			tally_and_finish();
		end
		if (!w)
			chk("prdata", x, PRDATA);
		chk("pslverr", e, PSLVERR);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLOCK);
	endtask : acc

	// waits for n header octets, then checks each and its end marker
	task automatic txchk(input int n, input logic [31:0] oct);
		int t;
		t = 0;
		while (peer.got.size() < n && t < 60) begin
			@(posedge CLOCK);
			t++;
		end
		if (t >= 60) begin
			chk("tx_count", n, peer.got.size());
			tally_and_finish();
		end
		for (int j = 0; j < n; j++)
			chk("tx_octet", {j == n - 1, oct[8*j+:8]}, peer.got.pop_front());
		@(posedge CLOCK);
	endtask : txchk

	initial begin
		{PSEL, PENABLE, PWRITE, SLOW, STALL} = '0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		RESET = 1'b1;
		repeat (5) @(posedge CLOCK);
		RESET <= 1'b0;
		@(posedge CLOCK);
		acc(0, REG_CTRL, 0, 32'h38, 0);
		acc(0, REG_CONN, 0, 32'h003F0000, 0);
		acc(0, REG_STATUS, 0, 32'h0, 0);
		acc(0, 8'h14, 0, 32'h0, 1);
		// header build table, odd rows against a slow line side
		foreach (rows[i]) begin
			SLOW <= (i % 2 == 1);
			acc(1, REG_CTRL, rows[i].ctrl, 0, 0);
			acc(1, REG_TXCMD, rows[i].cmd, 0, 0);
			txchk(rows[i].n, rows[i].oct);
		end
		acc(0, REG_STATUS, 0, 32'h2, 0);
		// window of one with two outstanding: refused and flagged, then cleared
		acc(1, REG_CTRL, 32'h08, 0, 0);
		acc(1, REG_TXCMD, 32'h004, 0, 1);
		acc(0, REG_STATUS, 0, 32'h02000002, 0);
		acc(1, REG_STATUS, 32'h02000000, 0, 0);
		// invalid ack first, then good, bad check, unknown id, over-long address
		peer.send('{8'h03, 8'h01, 8'h0A}, 1);
		peer.send('{8'h03, 8'h00, 8'h05}, 1);
		peer.send('{8'h03, 8'h02, 8'h00}, 0);
		peer.send('{8'h17, 8'h02, 8'h00}, 1);
		peer.send('{8'h02, 8'h00, 8'h02, 8'h00}, 1);
		acc(0, REG_STATUS, 0, 32'h1C010202, 0);
		acc(0, REG_RXHDR, 0, 32'h0000200C, 0);
		peer.send('{8'h03, 8'h02, 8'h04}, 1);
		acc(0, REG_STATUS, 0, 32'h1C020202, 0);
		// clear of the state variables, zero window becomes one
		acc(1, REG_CTRL, 32'h04, 0, 0);
		acc(0, REG_CTRL, 0, 32'h08, 0);
		acc(0, REG_STATUS, 0, 32'h1C000000, 0);
		acc(1, REG_STATUS, 32'h1C000000, 0, 0);
		// busy refusal while the line side stalls, then a bad format
		STALL <= 1'b1;
		acc(1, REG_TXCMD, 32'h005, 0, 0);
		acc(0, REG_TXCMD, 0, 32'h1, 0);
		acc(1, REG_TXCMD, 32'h004, 0, 1);
		STALL <= 1'b0;
		txchk(3, 32'h00000101);
		acc(1, REG_TXCMD, 32'h003, 0, 1);
		acc(0, REG_STATUS, 0, 32'h0, 0);
		acc(1, REG_CONN, 32'h00050155, 0, 0);
		acc(0, REG_CONN, 0, 32'h00050155, 0);
		acc(1, 8'h14, 32'h1, 0, 1);
		// mid-run reset with an information header stalled on the line side
		STALL <= 1'b1;
		acc(1, REG_TXCMD, 32'h000, 0, 0);
		acc(0, REG_STATUS, 0, 32'h01000001, 0);
		RESET <= 1'b1;
		repeat (3) @(posedge CLOCK);
		chk("tx_valid", 0, TX_VALID);
		chk("pready", 0, PREADY);
		RESET <= 1'b0;
		STALL <= 1'b0;
		acc(0, REG_CTRL, 0, 32'h38, 0);
		acc(0, REG_CONN, 0, 32'h003F0000, 0);
		acc(0, REG_STATUS, 0, 32'h0, 0);
		chk("tx_count", 0, peer.got.size());
		tally_and_finish();
	end
endmodule : lfhs_ctrl_tb
